// *** aux_source.sv ***
// External equipment model driving the auxiliary gate input
`timescale 1ns/100ps
module aux_source (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        idle_lvl,
  input  wire logic        go,
  input  wire logic [15:0] len,
  output logic             aux_in
);
  logic [15:0] left;

  // Pulse timer on the falling edge, clear of the sampling edge
  always_ff @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) left <= 16'h0;
    else if (go) left <= len;
    else if (left != 16'h0) left <= left - 16'h1;
  end

  // Pulse is the inverse of the idle level; spacing set by caller
  assign aux_in = (left != 16'h0) ? !idle_lvl : idle_lvl;
endmodule // aux_source

// *** burst_gate_assertions.sv ***
// Port-level checks for the burst gate generator
`timescale 1ns/100ps
module burst_gate_assertions
  import burst_gate_pkg::*;
#(
  parameter int CNT_W = 48
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire burst_gate_pkg::cfg_t  cfg,
  input wire logic                  aux_in,
  input wire logic [1:0]            bit_err,
  input wire logic                  capture_start,
  input wire burst_gate_pkg::stat_t stat,
  input wire logic [CNT_W-1:0]      bit_count,
  input wire logic [CNT_W-1:0]      err_count_a
);
  // ----
  // Mode decodes
  // ----
  wire rep_open = cfg.seq == SEQ_REPEAT && cfg.aux_fn != AUX_MASK;
  wire bad_pat  = cfg.seq == SEQ_BURST && cfg.pat == PAT_OTHER;
  wire masked   = cfg.aux_fn == AUX_MASK && !aux_in;
  wire en_low   = cfg.seq == SEQ_BURST && cfg.src == SRC_ENABLE &&
                  cfg.aux_fn == AUX_BURST && cfg.manual_delay == 32'h0 &&
                  cfg.dly == DLY_MANUAL && !aux_in;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Three cycles (four for a bad pattern) settle any gate register left from a mode change
  sequence s_rep_held;
    rep_open [*3];
  endsequence
  sequence s_bad_held;
    bad_pat [*4];
  endsequence

  chk_repeat_counts: assert property (
    s_rep_held |-> bit_count == $past(bit_count) + 1)
    else $error("repeat mode skipped a bit");
  chk_bit_step: assert property (
    bit_count == $past(bit_count) || bit_count == $past(bit_count) + 1)
    else $error("bit count moved by more than one");
  chk_err_gated: assert property (
    $changed(err_count_a) |-> $changed(bit_count))
    else $error("error counted outside the gate");
  chk_err_adds: assert property (
    $changed(bit_count) |->
      err_count_a == $past(err_count_a) + $past(bit_err[0]))
    else $error("error count missed a flagged bit");
  chk_pat_refused: assert property (
    s_bad_held |-> $stable(bit_count))
    else $error("burst counted an unsupported pattern");
  chk_pat_flag: assert property (
    s_bad_held |-> stat.cfg_error)
    else $error("unsupported pattern not flagged");
  chk_mask_holds: assert property (
    masked [*7] |=> $stable(bit_count))
    else $error("bit counted while masked");
  chk_enable_low: assert property (
    en_low [*8] |=> $stable(bit_count))
    else $error("bit counted with enable low");
  chk_capture_pulse: assert property (
    capture_start |-> cfg.aux_fn == AUX_CAPTURE ##1 !capture_start)
    else $error("capture start wrong mode or length");
  chk_auto_needs_sync: assert property (
    (!cfg.frame_sync_on) [*3] |-> !stat.auto_busy)
    else $error("auto delay ran with frame sync off");
  chk_delay_grid: assert property (
    stat.applied_delay[2:0] == 3'h0)
    else $error("applied delay off the bit grid");
endmodule // burst_gate_assertions

bind burst_gate_generator burst_gate_assertions #(.CNT_W(CNT_W)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .aux_in(aux_in),
  .bit_err(bit_err), .capture_start(capture_start), .stat(stat),
  .bit_count(bit_count), .err_count_a(err_count_a));

// *** burst_gate_generator.sv ***
// Receive burst gate, delay alignment, masking and bit/error counting
`timescale 1ns/100ps
module burst_gate_generator #(
  parameter int CNT_W = 48
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire burst_gate_pkg::cfg_t cfg,
  input  wire logic                 aux_in,
  input  wire logic                 sync_lock,
  input  wire logic [1:0]           bit_err,
  output logic                      capture_start,
  output burst_gate_pkg::stat_t     stat,
  output logic [CNT_W-1:0]          bit_count,
  output logic [CNT_W-1:0]          err_count_a,
  output logic [CNT_W-1:0]          err_count_b
);
  import burst_gate_pkg::*;

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  // Round down onto the step grid; keeps odd values usable
  function automatic logic [32:0] snap(input logic [32:0] v,
                                       input int          sh);
    snap = (v >> sh) << sh;
  endfunction

  function automatic logic in_rng(input logic [32:0] v,
                                  input logic [32:0] lo,
                                  input logic [32:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  //----------------------------------------------------------------
  // Auxiliary pin synchroniser
  //----------------------------------------------------------------
  logic aux_s1;
  logic aux_s2;
  logic aux_s3;
  logic aux_lvl;
  logic aux_prev;
  wire  aux_rise = aux_lvl & ~aux_prev;

  // Three stages; level moves only once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_s1   <= 1'b0;
      aux_s2   <= 1'b0;
      aux_s3   <= 1'b0;
      aux_lvl  <= 1'b0;
      aux_prev <= 1'b0;
    end else begin
      aux_s1   <= aux_in;
      aux_s2   <= aux_s1;
      aux_s3   <= aux_s2;
      aux_prev <= aux_lvl;
      if (aux_s2 == aux_s3) begin
        aux_lvl <= aux_s3;
      end
    end
  end

  //----------------------------------------------------------------
  // Settings snapped to the grid and checked
  //----------------------------------------------------------------
  wire        dual    = cfg.dual_channel_combined;
  wire        burst   = (cfg.seq == SEQ_BURST);
  wire        use_int = (cfg.src == SRC_INTERNAL);
  wire        use_trg = (cfg.src == SRC_TRIGGER);
  wire        aux_brs = (cfg.aux_fn == AUX_BURST);
  wire [32:0] en_per  = snap(cfg.enable_period,
                             dual ? EN_SH_2CH : EN_SH_1CH);
  wire [32:0] cyc_per = snap(cfg.burst_cycle,
                             dual ? EN_SH_2CH : EN_SH_1CH);
  wire [32:0] en_min  = dual ? EN_MIN_2CH : EN_MIN_1CH;
  wire [32:0] en_max  = dual ? (use_int ? EN_INT_2CH : EN_TRG_2CH)
                             : (use_int ? EN_INT_1CH : EN_TRG_1CH);
  wire [32:0] cyc_min = dual ? CYC_MIN_2CH : CYC_MIN_1CH;
  wire [32:0] cyc_max = dual ? CYC_MAX_2CH : CYC_MAX_1CH;
  wire [32:0] dis_min = dual ? DIS_MIN_2CH : DIS_MIN_1CH;
  wire [32:0] dly_max = dual ? DLY_MAX_2CH : DLY_MAX_1CH;
  wire [32:0] man_raw = snap({1'b0, cfg.manual_delay},
                             dual ? DLY_SH_2CH : DLY_SH_1CH);
  // Out-of-range delay is clamped rather than refused
  wire [32:0] man_dly = (man_raw > dly_max) ? dly_max : man_raw;

  // Unsupported pattern types may not run in burst
  wire pat_bad = (cfg.pat == PAT_OTHER);
  wire en_bad  = (use_int | use_trg) &
                 ~in_rng(en_per, en_min, en_max);
  wire cyc_bad = use_int & (~in_rng(cyc_per, cyc_min, cyc_max) |
                 (cyc_per < en_per + dis_min));
  wire cfg_err = burst & (pat_bad | en_bad | cyc_bad);
  wire run     = burst & ~cfg_err;

  //----------------------------------------------------------------
  // Gate sources
  //----------------------------------------------------------------
  logic [32:0] cyc_cnt;
  logic [32:0] trg_cnt;

  // Internal cycle counter wraps once per burst cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_cnt <= 33'h0_0000_0000;
    end else if (!run || !use_int ||
                 cyc_cnt >= cyc_per - 33'h0_0000_0001) begin
      cyc_cnt <= 33'h0_0000_0000;
    end else begin
      cyc_cnt <= cyc_cnt + 33'h0_0000_0001;
    end
  end

  // Trigger window; a new edge inside the window is ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trg_cnt <= 33'h0_0000_0000;
    end else if (!run || !use_trg || !aux_brs) begin
      trg_cnt <= 33'h0_0000_0000;
    end else if (trg_cnt == 33'h0_0000_0000) begin
      if (aux_rise) begin
        trg_cnt <= en_per;
      end
    end else begin
      trg_cnt <= trg_cnt - 33'h0_0000_0001;
    end
  end

  wire src_int = use_int & (cyc_cnt < en_per);
  wire src_trg = (trg_cnt != 33'h0_0000_0000);
  wire src_ena = (cfg.src == SRC_ENABLE) & aux_brs & aux_lvl;
  wire src_lvl = run & (src_int | src_trg | src_ena);

  logic src_prev;
  wire  src_rise = src_lvl & ~src_prev;
  wire  src_fall = ~src_lvl & src_prev;

  //----------------------------------------------------------------
  // Automatic delay search
  //----------------------------------------------------------------
  auto_st_t    a_st;
  auto_st_t    next_a_st;
  logic [32:0] a_cnt;
  logic [32:0] a_dly;
  logic        a_ok;
  logic        dly_prev;
  logic        lock_prev;
  wire         want_auto = (cfg.dly == DLY_AUTO) & cfg.frame_sync_on;
  // Search reruns only on a manual to auto change
  wire         a_start   = (cfg.dly == DLY_AUTO) & ~dly_prev;
  wire         lock_rise = sync_lock & ~lock_prev;

  // Search sequence: wait for source edge, time until lock
  always_comb begin
    next_a_st = a_st;
    case (a_st)
      A_IDLE: begin
        if (a_start && want_auto && run) begin
          next_a_st = A_WAIT;
        end
      end
      A_WAIT: begin
        if (src_rise) begin
          next_a_st = A_MEAS;
        end
      end
      A_MEAS: begin
        if (lock_rise) begin
          next_a_st = A_DONE;
        end
      end
      A_DONE: begin
        if (a_start) begin
          next_a_st = A_WAIT;
        end
      end
      default: next_a_st = A_IDLE;
    endcase
    if (!want_auto || !run) begin
      next_a_st = A_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_st      <= A_IDLE;
      dly_prev  <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      a_st      <= next_a_st;
      dly_prev  <= (cfg.dly == DLY_AUTO);
      lock_prev <= sync_lock;
    end
  end

  // Offset from source edge to frame lock becomes the delay
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_cnt <= 33'h0_0000_0000;
      a_dly <= 33'h0_0000_0000;
      a_ok  <= 1'b0;
    end else begin
      if (a_st == A_MEAS) begin
        a_cnt <= src_rise ? 33'h0_0000_0000
                          : a_cnt + 33'h0_0000_0001;
      end else begin
        a_cnt <= 33'h0_0000_0000;
      end
      if (a_st == A_MEAS && lock_rise) begin
        a_dly <= snap(a_cnt, dual ? DLY_SH_2CH : DLY_SH_1CH);
        a_ok  <= 1'b1;
      end else if (next_a_st == A_IDLE || next_a_st == A_WAIT) begin
        a_ok  <= 1'b0;
      end
    end
  end

  wire [32:0] dly = (cfg.dly == DLY_AUTO) ? (a_ok ? a_dly : 33'h0)
                                          : man_dly;

  //----------------------------------------------------------------
  // Edge delay lines: index 0 opens, index 1 closes
  //----------------------------------------------------------------
  logic [1:0]  pend;
  logic [32:0] dcnt [2];
  logic [1:0]  evt;
  wire  [1:0]  edg = {src_fall, src_rise};
  wire         dly_zero = (dly == 33'h0_0000_0000);

  // One edge of each kind in flight; a repeat edge inside the delay restarts the line and the earlier edge is lost
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      evt[i] = (edg[i] & dly_zero) |
               (pend[i] & (dcnt[i] == 33'h0_0000_0001));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend     <= 2'h0;
      dcnt[0]  <= 33'h0_0000_0000;
      dcnt[1]  <= 33'h0_0000_0000;
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_lvl;
      for (int i = 0; i < 2; i++) begin
        if (!run) begin
          pend[i] <= 1'b0;
        end else if (edg[i] && !dly_zero) begin
          pend[i] <= 1'b1;
          dcnt[i] <= dly;
        end else if (pend[i]) begin
          dcnt[i] <= dcnt[i] - 33'h0_0000_0001;
          if (dcnt[i] == 33'h0_0000_0001) begin
            pend[i] <= 1'b0;
          end
        end
      end
    end
  end

  //----------------------------------------------------------------
  // Gate, mask and counters
  //----------------------------------------------------------------
  logic gate_q;

  // Opening wins, so back-to-back bursts leave no hole
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else if (!run) begin
      gate_q <= 1'b0;
    end else if (evt[0]) begin
      gate_q <= 1'b1;
    end else if (evt[1]) begin
      gate_q <= 1'b0;
    end
  end

  wire gate_open = burst ? (gate_q & run) : 1'b1;
  wire mask_pass = (cfg.aux_fn != AUX_MASK) | aux_lvl;
  wire measuring = gate_open & mask_pass;

  // Both channels share the one gate and mask
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_count   <= '0;
      err_count_a <= '0;
      err_count_b <= '0;
    end else if (measuring) begin
      bit_count   <= bit_count + 1'b1;
      err_count_a <= err_count_a + CNT_W'(bit_err[0]);
      err_count_b <= err_count_b + CNT_W'(bit_err[1]);
    end
  end

  // Capture start is a registered one-bit pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_start <= 1'b0;
    end else begin
      capture_start <= (cfg.aux_fn == AUX_CAPTURE) & aux_rise;
    end
  end

  // Status snapshot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= '0;
    end else begin
      stat.gate_open     <= gate_open;
      stat.measuring     <= measuring;
      stat.cfg_error     <= cfg_err;
      stat.auto_busy     <= (a_st == A_WAIT) | (a_st == A_MEAS);
      stat.auto_valid    <= a_ok;
      stat.applied_delay <= dly;
    end
  end

endmodule // burst_gate_generator

// *** burst_gate_pkg.sv ***
// Constants, modes and carriers for the receive burst gate generator
//------------------------------------------------------------------
//------------------------------------------------------------------
package burst_gate_pkg;
  localparam int          VAL_W       = 33;
  localparam int          EN_SH_1CH   = 8;
  localparam int          EN_SH_2CH   = 9;
  localparam int          DLY_SH_1CH  = 3;
  localparam int          DLY_SH_2CH  = 4;
  localparam logic [32:0] EN_MIN_1CH  = 33'h0_0000_3200;
  localparam logic [32:0] EN_INT_1CH  = 33'h0_7FFF_FC00;
  localparam logic [32:0] EN_TRG_1CH  = 33'h0_7FFF_FF00;
  localparam logic [32:0] CYC_MIN_1CH = 33'h0_0000_6400;
  localparam logic [32:0] CYC_MAX_1CH = 33'h0_8000_0000;
  localparam logic [32:0] EN_MIN_2CH  = 33'h0_0000_6400;
  localparam logic [32:0] EN_INT_2CH  = 33'h0_FFFF_F800;
  localparam logic [32:0] EN_TRG_2CH  = 33'h0_FFFF_FE00;
  localparam logic [32:0] CYC_MIN_2CH = 33'h0_0000_C800;
  localparam logic [32:0] CYC_MAX_2CH = 33'h1_0000_0000;
  localparam logic [32:0] DIS_MIN_1CH = 33'h0_0000_0200;
  localparam logic [32:0] DIS_MIN_2CH = 33'h0_0000_0400;
  localparam logic [32:0] DLY_MAX_1CH = 33'h0_7FFF_FFF8;
  localparam logic [32:0] DLY_MAX_2CH = 33'h0_FFFF_FFF0;

  typedef enum logic {SEQ_REPEAT = 1'h0, SEQ_BURST = 1'h1} seq_t;
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0, SRC_TRIGGER = 2'h1, SRC_ENABLE = 2'h2
  } src_t;
  typedef enum logic [1:0] {
    AUX_BURST = 2'h0, AUX_MASK = 2'h1, AUX_CAPTURE = 2'h2
  } aux_fn_t;
  typedef enum logic [2:0] {
    PAT_PRBS = 3'h0, PAT_ZERO_SUB = 3'h1, PAT_DATA = 3'h2,
    PAT_MIXED = 3'h3, PAT_OTHER = 3'h4
  } pat_t;
  typedef enum logic {DLY_MANUAL = 1'h0, DLY_AUTO = 1'h1} dly_t;
  typedef enum logic [3:0] {
    A_IDLE = 4'h1, A_WAIT = 4'h2, A_MEAS = 4'h4, A_DONE = 4'h8
  } auto_st_t;

  typedef struct packed {
    seq_t        seq;
    src_t        src;
    aux_fn_t     aux_fn;
    pat_t        pat;
    dly_t        dly;
    logic        dual_channel_combined;
    logic        frame_sync_on;
    logic [32:0] enable_period;
    logic [32:0] burst_cycle;
    logic [31:0] manual_delay;
  } cfg_t;

  typedef struct packed {
    logic        gate_open;
    logic        measuring;
    logic        cfg_error;
    logic        auto_busy;
    logic        auto_valid;
    logic [32:0] applied_delay;
  } stat_t;
endpackage

// *** tb_burst_gate_generator.sv ***
// Self-checking bench for the burst gate generator
`timescale 1ns/100ps
module tb_burst_gate_generator;
  import burst_gate_pkg::*;
  logic        sys_clk;
  logic        rst_n;
  cfg_t        cfg;
  logic        sync_lock;
  logic [1:0]  bit_err;
  logic        idle_lvl;
  logic        go;
  logic [15:0] len;
  logic        aux_in;
  logic        capture_start;
  stat_t       stat;
  logic [47:0] bit_count;
  logic [47:0] err_count_a;
  logic [47:0] err_count_b;
  logic [47:0] b0;
  logic [47:0] a0;
  logic [47:0] e0;
  int          n_fail;
  int          compares;

  burst_gate_generator DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
    .aux_in(aux_in), .sync_lock(sync_lock), .bit_err(bit_err),
    .capture_start(capture_start), .stat(stat), .bit_count(bit_count),
    .err_count_a(err_count_a), .err_count_b(err_count_b));
  aux_source u_src (.sys_clk(sys_clk), .rst_n(rst_n), .idle_lvl(idle_lvl),
    .go(go), .len(len), .aux_in(aux_in));

  // 100 MHz bit clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----
  // Shared helpers
  // ----
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic snap;
    b0 = bit_count;
    a0 = err_count_a;
    e0 = err_count_b;
  endtask
  // Source flips away from idle for n bits
  task automatic pulse(input logic [15:0] n);
    len <= n;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_repeat;
    bit_err = 2'h1;
    cyc(4);
    snap;
    cyc(100);
    check(bit_count - b0, 48'h64);
    check(err_count_a - a0, 48'h64);
    check(err_count_b - e0, 48'h0);
  endtask
  // Both channels share one mask; 30 of 61 bits held low
  task automatic t_mask;
    idle_lvl = 1'b1;
    cfg.aux_fn = AUX_MASK;
    cfg.dual_channel_combined = 1'b1;
    bit_err = 2'h3;
    cyc(10);
    snap;
    pulse(16'h1E);
    cyc(60);
    check(bit_count - b0, 48'h1F);
    check(err_count_a - a0, 48'h1F);
    check(err_count_b - e0, 48'h1F);
  endtask
  // Every pattern kind under the level enable; only four are accepted
  task automatic t_enable;
    cfg = '0;
    cfg.seq = SEQ_BURST;
    cfg.src = SRC_ENABLE;
    idle_lvl = 1'b0;
    bit_err = 2'h0;
    for (int i = 0; i < 5; i++) begin
      cfg.pat = pat_t'(i);
      cyc(10);
      check(stat.cfg_error, i == 4);
      snap;
      pulse(16'h28);
      cyc(60);
      check(bit_count - b0, (i == 4) ? 48'h0 : 48'h28);
    end
  endtask
  task automatic t_delay;
    cfg.pat = PAT_PRBS;
    cfg.manual_delay = 32'h20;
    cyc(10);
    snap;
    pulse(16'h28);
    cyc(20);
    check(bit_count - b0, 48'h0);
    cyc(80);
    check(bit_count - b0, 48'h28);
    // Over-range delay clamps; dual channel rounds to its coarser step
    cfg.manual_delay = 32'hFFFF_FFFF;
    cyc(2);
    check(stat.applied_delay, DLY_MAX_1CH);
    cfg.dual_channel_combined = 1'b1;
    cfg.manual_delay = 32'h1F;
    cyc(2);
    check(stat.applied_delay, 33'h10);
    cfg.dual_channel_combined = 1'b0;
    cfg.manual_delay = 32'h0;
    cyc(2);
  endtask
  // A second edge inside the window must not stretch it
  task automatic t_trigger;
    cfg.src = SRC_TRIGGER;
    cfg.enable_period = 33'h3200;
    cyc(10);
    check(stat.cfg_error, 1'b0);
    snap;
    pulse(16'h5);
    cyc(200);
    check(stat.gate_open, 1'b1);
    check(stat.measuring, 1'b1);
    pulse(16'h5);
    cyc(12800);
    check(bit_count - b0, 48'h3200);
  endtask
  // Off-grid period rounds down; two full cycles give two windows
  task automatic t_internal;
    cfg.src = SRC_INTERNAL;
    cfg.burst_cycle = 33'h6400;
    cfg.enable_period = 33'h3264;
    cyc(100);
    check(stat.cfg_error, 1'b0);
    snap;
    cyc(51200);
    check(bit_count - b0, 48'h6400);
    cfg.enable_period = 33'h6300;
    cyc(4);
    check(stat.cfg_error, 1'b1);
    check(stat.gate_open, 1'b0);
  endtask
  // Auto delay idles without frame sync; manual to auto starts it
  task automatic t_auto;
    logic in_win;
    cfg = '0;
    cfg.seq = SEQ_BURST;
    cfg.src = SRC_ENABLE;
    cfg.dly = DLY_AUTO;
    cyc(4);
    check(stat.auto_busy, 1'b0);
    cfg.dly = DLY_MANUAL;
    cfg.frame_sync_on = 1'b1;
    cyc(1);
    cfg.dly = DLY_AUTO;
    cyc(3);
    check(stat.auto_busy, 1'b1);
    check(stat.auto_valid, 1'b0);
    // Lock arrives about 40 bits after the source edge
    pulse(16'h8);
    cyc(40);
    sync_lock = 1'b1;
    cyc(3);
    sync_lock = 1'b0;
    check(stat.auto_busy, 1'b0);
    check(stat.auto_valid, 1'b1);
    check(stat.applied_delay[2:0], 3'h0);
    in_win = (stat.applied_delay >= 33'h18) && (stat.applied_delay <= 33'h28);
    check(in_win, 1'b1);
    // The learned delay now holds the window back
    snap;
    pulse(16'h28);
    cyc(30);
    check(bit_count - b0, 48'h0);
    cyc(90);
    check(bit_count - b0, 48'h28);
  endtask
  task automatic t_capture;
    int k;
    cfg = '0;
    cfg.aux_fn = AUX_CAPTURE;
    cyc(4);
    pulse(16'hA);
    for (k = 0; k < 20 && capture_start !== 1'b1; k++) cyc(1);
    if (k == 20) begin
      n_fail++;
      tally_and_finish;
    end
    check(capture_start, 1'b1);
    cyc(1);
    check(capture_start, 1'b0);
  endtask

  initial begin
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    cfg = '0;
    sync_lock = 1'b0;
    bit_err = 2'h0;
    idle_lvl = 1'b0;
    go = 1'b0;
    len = 16'h0;
    cyc(2);
    rst_n = 1'b1;
    cyc(2);
    t_repeat;
    t_mask;
    t_enable;
    t_delay;
    t_trigger;
    t_internal;
    t_auto;
    t_capture;
    tally_and_finish;
  end
endmodule // tb_burst_gate_generator
